// ==== hw/dcm_match.sv ====
// debug comparator address and data match registers with their comparators
// assumes a classic wishbone master and a cpu bus observed in the same clock
//
// How it works
// - mid register holds address bits 15:8
// - low register holds address bits 7:0
// - reference bit zero wants low, one high
// - address registers read in any view but none, written when disarmed
// - data registers read only in view a
// - data registers written in view a, disarmed
// - data high holds data bits 15:8
// - data low holds data bits 7:0
// - data reference zero wants low, one high
// - data high bit compared only when mask set
// - data compare only while tagging is off
// - only comparator a compares data
// - view selects comparator a, b, c or none
// - cleared mask bit lets any value match
// - high register holds address bits 17:16
`timescale 1ns/1ps
module dcm_match
  import dcm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // observed cpu bus
  input wire logic i_bus_valid,
  input wire logic [DCM_ADDR_W-1:0] i_bus_addr,
  input wire logic [DCM_DATA_W-1:0] i_bus_data,
  // comparator results
  output logic [2:0] o_match
);

  dcm_state_t st_q; // registered state
  dcm_state_t st_d; // next state
  logic req; // new bus request this cycle
  logic wr; // byte lane zero write
  logic [5:0] idx; // register index
  logic [7:0] wbyte; // written byte
  logic vis; // a comparator is in view
  logic view_a; // comparator a is in view
  logic [2:0] addr_hit; // per comparator address equality
  logic data_hit; // comparator a data equality
  logic [2:0] match_now; // combined match this cycle

  // one request per handshake; ack drops the cycle after it was given
  // gating on ack stops a master that holds stb from being taken twice
  assign req = i_wb_cyc && i_wb_stb && !st_q.ack;
  assign wr = req && i_wb_we && i_wb_sel[0];
  assign idx = i_wb_adr[7:2];
  assign wbyte = i_wb_dat[7:0];
  assign vis = st_q.view != DCM_VIEW_NONE;
  assign view_a = st_q.view == DCM_VIEW_A;

  // address comparison per comparator, all 18 bits exact
  // equality only: range modes are not built into this block
  for (genvar g = 0; g < DCM_NCMP; g++) begin : g_cmp
    assign addr_hit[g] = i_bus_valid && st_q.cmp_en[g] &&
                         (i_bus_addr == st_q.ref_addr[g]);
  end

  // data test on comparator a; masked bits never block a match
  // limitation: no low mask register, so data bits 7:0 always take part
  assign data_hit = st_q.tag_a ||
    (((i_bus_data ^ {st_q.data_hi, st_q.data_lo}) &
      {st_q.mask_hi, DCM_LOW_MASK}) == 16'h0000);

  // b and c are address only
  assign match_now = addr_hit & {1'b1, 1'b1, data_hit};

  // next state: register access and match capture
  // reads and writes decode the same index, so outside the read-only status index a read returns
  // exactly the byte that a write to that index would reach
  always_comb begin
    st_d = st_q;
    st_d.ack = req;
    st_d.match = match_now;
    if (req) begin
      st_d.rdat = DCM_BYTE_ZERO; // unmapped and hidden read as zero
    end
    unique case (idx)
      DCM_IDX_ADDR_HIGH: begin
        // address high, writes lock while armed
        if (req && vis) begin
          st_d.rdat = {6'h00, st_q.ref_addr[st_q.view][17:16]};
        end
        if (wr && vis && !st_q.armed) begin
          st_d.ref_addr[st_q.view][17:16] = wbyte[1:0];
        end
      end
      DCM_IDX_ADDR_MID: begin
        // address mid, same view and lock as the high byte
        if (req && vis) begin
          st_d.rdat = st_q.ref_addr[st_q.view][15:8];
        end
        if (wr && vis && !st_q.armed) begin
          st_d.ref_addr[st_q.view][15:8] = wbyte;
        end
      end
      DCM_IDX_ADDR_LOW: begin
        // address low, same view and lock as the high byte
        if (req && vis) begin
          st_d.rdat = st_q.ref_addr[st_q.view][7:0];
        end
        if (wr && vis && !st_q.armed) begin
          st_d.ref_addr[st_q.view][7:0] = wbyte;
        end
      end
      DCM_IDX_DATA_HIGH: begin
        // data registers exist for comparator a only
        if (req && view_a) begin
          st_d.rdat = st_q.data_hi;
        end
        if (wr && view_a && !st_q.armed) begin
          st_d.data_hi = wbyte;
        end
      end
      DCM_IDX_DATA_LOW: begin
        // data low reference, hidden outside view a
        if (req && view_a) begin
          st_d.rdat = st_q.data_lo;
        end
        if (wr && view_a && !st_q.armed) begin
          st_d.data_lo = wbyte;
        end
      end
      DCM_IDX_DATA_HMASK: begin
        // data high mask, hidden outside view a
        if (req && view_a) begin
          st_d.rdat = st_q.mask_hi;
        end
        if (wr && view_a && !st_q.armed) begin
          st_d.mask_hi = wbyte;
        end
      end
      DCM_IDX_CTRL: begin
        // control stays writable so software can disarm
        // trade-off: the lock is not applied here, so software may also
        // move the view while armed; only the references and the data high mask are frozen
        if (req) begin
          st_d.rdat = {1'b0, st_q.cmp_en, st_q.armed, st_q.tag_a, st_q.view};
        end
        if (wr) begin
          st_d.view = wbyte[DCM_CTL_VIEW_LSB+:2];
          st_d.tag_a = wbyte[DCM_CTL_TAG];
          st_d.armed = wbyte[DCM_CTL_ARM];
          st_d.cmp_en = wbyte[DCM_CTL_EN_LSB+:3];
        end
      end
      DCM_IDX_STATUS: begin
        // read only view of last cycle's matches
        if (req) begin
          st_d.rdat = {5'h00, st_q.match};
        end
      end
      default: begin
        // unmapped: acknowledged, reads zero, writes dropped
      end
    endcase
  end

  // single state register, constant under reset
  // every field resets to zero, which leaves all comparators off
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= DCM_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  // read data stands until the next taken request, so a slow master
  // may take it late without loss
  assign o_wb_ack = st_q.ack;
  assign o_wb_dat = {24'h00_0000, st_q.rdat};
  assign o_match = st_q.match;

  // checks on what the block drives
  // all in the one clock domain, so one default clocking serves them
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // control is left out: it must stay writable, or an armed block
  // could never be released by software
  logic lock_wr; // any write refused by the lock
  assign lock_wr = wr && st_q.armed && idx != DCM_IDX_CTRL;

  // register file: a write is visible the cycle after it is taken
  a_mid_write: assert property (
    wr && idx == DCM_IDX_ADDR_MID && vis && !st_q.armed |=>
    st_q.ref_addr[$past(st_q.view)][15:8] == $past(wbyte))
    else $error("mid write not stored");

  a_low_write: assert property (
    wr && idx == DCM_IDX_ADDR_LOW && vis && !st_q.armed |=>
    st_q.ref_addr[$past(st_q.view)][7:0] == $past(wbyte))
    else $error("low write not stored");

  // comparators: a match flag always traces back to the cycle before
  a_addr_polarity: assert property (
    o_match[1] |-> $past(i_bus_addr) == $past(st_q.ref_addr[1]))
    else $error("b matched a different address");

  a_armed_lock: assert property (
    lock_wr |=> $stable(st_q.ref_addr) && $stable(st_q.data_hi) &&
    $stable(st_q.data_lo) && $stable(st_q.mask_hi))
    else $error("write while armed changed a register");

  a_data_hidden: assert property (
    req && !i_wb_we && idx == DCM_IDX_DATA_HIGH && !view_a |=>
    o_wb_ack && o_wb_dat == 32'h0000_0000)
    else $error("data high visible outside view a");

  a_data_view: assert property (
    wr && !view_a && idx == DCM_IDX_DATA_LOW |=> $stable(st_q.data_lo))
    else $error("data low written outside view a");

  a_data_high_cmp: assert property (
    o_match[0] && !$past(st_q.tag_a) && $past(st_q.mask_hi) == 8'hFF |->
    $past(i_bus_data[15:8]) == $past(st_q.data_hi))
    else $error("a matched with wrong data high");

  a_data_low_cmp: assert property (
    o_match[0] && !$past(st_q.tag_a) |->
    $past(i_bus_data[7:0]) == $past(st_q.data_lo))
    else $error("a matched with wrong data low");

  a_data_polarity: assert property (
    addr_hit[0] && !st_q.tag_a &&
    i_bus_data == {st_q.data_hi, st_q.data_lo} |=> o_match[0])
    else $error("a missed equal data");

  a_mask_gate: assert property (
    addr_hit[0] && !st_q.tag_a &&
    ((i_bus_data[15:8] ^ st_q.data_hi) & st_q.mask_hi) != 8'h00 |=>
    !o_match[0])
    else $error("a matched on unmasked data mismatch");

  a_tag_ignores: assert property (
    addr_hit[0] && st_q.tag_a |=> o_match[0])
    else $error("tagged a blocked by data");

  a_bc_no_data: assert property (
    addr_hit[2:1] == 2'b11 |=> o_match[2:1] == 2'b11)
    else $error("b or c depended on data");

  a_view_none: assert property (
    req && !i_wb_we && idx == DCM_IDX_ADDR_MID && !vis ##1
    o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("view none exposed a comparator");

  a_mask_free: assert property (
    addr_hit[0] && !st_q.tag_a && st_q.mask_hi == 8'h00 &&
    i_bus_data[7:0] == st_q.data_lo |=> o_match[0])
    else $error("cleared mask still compared");

  a_addr_high: assert property (
    o_match[2] |-> $past(i_bus_addr[17:16]) == $past(st_q.ref_addr[2][17:16]))
    else $error("c matched with wrong high bits");

  a_match_cause: assert property (
    $rose(o_match[1]) |-> $past(i_bus_valid) && $past(st_q.cmp_en[1]))
    else $error("b matched without a valid enabled cycle");

  // further checks on reads, writes and quiet outputs
  a_high_write: assert property (
    wr && idx == DCM_IDX_ADDR_HIGH && vis && !st_q.armed |=>
    st_q.ref_addr[$past(st_q.view)][17:16] == $past(wbyte[1:0]))
    else $error("high write not stored");

  a_mid_read: assert property (
    req && !i_wb_we && idx == DCM_IDX_ADDR_MID && vis |=>
    o_wb_ack && o_wb_dat[7:0] == st_q.ref_addr[$past(st_q.view)][15:8])
    else $error("mid read returned a wrong value");

  a_data_write: assert property (
    wr && idx == DCM_IDX_DATA_HIGH && view_a && !st_q.armed |=>
    st_q.data_hi == $past(wbyte))
    else $error("data high write not stored");

  a_none_write: assert property (
    wr && idx == DCM_IDX_ADDR_MID && !vis |=> $stable(st_q.ref_addr))
    else $error("write with no comparator in view landed");

  a_off_quiet: assert property (
    !st_q.cmp_en[0] |=> !o_match[0])
    else $error("disabled comparator a matched");

  a_idle_quiet: assert property (
    !i_bus_valid |=> o_match == 3'b000)
    else $error("match without a valid bus cycle");

  a_data_low_read: assert property (
    req && !i_wb_we && idx == DCM_IDX_DATA_LOW && view_a |=>
    o_wb_dat[7:0] == $past(st_q.data_lo))
    else $error("data low read wrong in view a");

  a_low_mismatch: assert property (
    addr_hit[0] && !st_q.tag_a && i_bus_data[7:0] != st_q.data_lo |=>
    !o_match[0])
    else $error("a matched on data low mismatch");

  a_mask_hidden: assert property (
    req && !i_wb_we && idx == DCM_IDX_DATA_HMASK && !view_a |=>
    o_wb_dat == 32'h0000_0000)
    else $error("data mask visible outside view a");

  a_disarm_write: assert property (
    wr && idx == DCM_IDX_CTRL |=> st_q.armed == $past(wbyte[DCM_CTL_ARM]))
    else $error("control write did not set the arm state");

  a_b_address: assert property (
    addr_hit[1] |=> o_match[1])
    else $error("b missed an equal address");

  a_c_address: assert property (
    addr_hit[2] |=> o_match[2])
    else $error("c missed an equal address");

  a_status_read: assert property (
    req && !i_wb_we && idx == DCM_IDX_STATUS |=>
    o_wb_dat[2:0] == $past(st_q.match))
    else $error("status read lost the match flags");

  a_ack_pulse: assert property (
    req |=> o_wb_ack ##1 !o_wb_ack)
    else $error("acknowledge was not a single pulse");

  // main scenarios
  c_write_ok: cover property (wr && idx == DCM_IDX_ADDR_MID && !st_q.armed);
  c_write_locked: cover property (lock_wr);
  c_match_a_data: cover property (o_match[0] && !st_q.tag_a);
  c_match_bc: cover property (o_match[1] && o_match[2]);
  // reads with nothing in view must still be acknowledged
  c_read_none: cover property (req && !i_wb_we && !vis);

endmodule : dcm_match

// ==== include/dcm_pkg.sv ====
// constants and state type for the debug comparator match registers
// assumes a byte wide register file reached over a 32-bit wishbone slave
package dcm_pkg;
  // observed bus widths and comparator count
  localparam int unsigned DCM_NCMP = 3;
  localparam int unsigned DCM_ADDR_W = 18;
  localparam int unsigned DCM_DATA_W = 16;
  // register indexes, byte address is four times the index
  localparam logic [5:0] DCM_IDX_ADDR_HIGH = 6'h29;
  localparam logic [5:0] DCM_IDX_ADDR_MID = 6'h2A;
  localparam logic [5:0] DCM_IDX_ADDR_LOW = 6'h2B;
  localparam logic [5:0] DCM_IDX_DATA_HIGH = 6'h2C;
  localparam logic [5:0] DCM_IDX_DATA_LOW = 6'h2D;
  localparam logic [5:0] DCM_IDX_DATA_HMASK = 6'h2E;
  localparam logic [5:0] DCM_IDX_CTRL = 6'h30;
  localparam logic [5:0] DCM_IDX_STATUS = 6'h31;
  // view select codes
  localparam logic [1:0] DCM_VIEW_A = 2'b00;
  localparam logic [1:0] DCM_VIEW_B = 2'b01;
  localparam logic [1:0] DCM_VIEW_C = 2'b10;
  localparam logic [1:0] DCM_VIEW_NONE = 2'b11;
  // control register field positions
  localparam int unsigned DCM_CTL_VIEW_LSB = 0;
  localparam int unsigned DCM_CTL_TAG = 2;
  localparam int unsigned DCM_CTL_ARM = 3;
  localparam int unsigned DCM_CTL_EN_LSB = 4;
  // low data byte is always compared, its mask register is not here
  localparam logic [7:0] DCM_LOW_MASK = 8'hFF;
  localparam logic [7:0] DCM_BYTE_ZERO = 8'h00;
  // whole block state
  typedef struct packed {
    logic [2:0][17:0] ref_addr; // per comparator address reference
    logic [7:0] data_hi; // comparator a data reference 15:8
    logic [7:0] data_lo; // comparator a data reference 7:0
    logic [7:0] mask_hi; // comparator a data mask 15:8
    logic [1:0] view; // which comparator the window shows
    logic tag_a; // comparator a opcode tagging
    logic armed; // debug module armed
    logic [2:0] cmp_en; // comparator enables
    logic ack; // wishbone acknowledge
    logic [7:0] rdat; // read data byte
    logic [2:0] match; // registered match flags
  } dcm_state_t;
  localparam dcm_state_t DCM_STATE_RST = '0;
endpackage : dcm_pkg

// ==== tb/dcm_cpu_model.sv ====
// cpu bus model: puts one observed bus cycle on the lines per call
// assumes the caller enters just after a rising edge of i_clk
`timescale 1ns/1ps
module dcm_cpu_model (
  // clock
  input wire logic i_clk,
  // observed bus
  output logic o_valid,
  output logic [17:0] o_addr,
  output logic [15:0] o_data
);
  // idle lines at time zero
  initial begin
    o_valid = 1'b0;
    o_addr = '0;
    o_data = '0;
  end
  // one valid cycle, then lines flip so stale values never look held
  task cycle(input logic [17:0] a, input logic [15:0] d);
    o_valid <= 1'b1;
    o_addr <= a;
    o_data <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    o_data <= ~d;
  endtask : cycle
endmodule : dcm_cpu_model

// ==== tb/dcm_match_test.sv ====
// self-checking bench for the debug comparator match registers
// assumes a one-cycle wishbone ack and a one-cycle match delay
`timescale 1ns/1ps
module dcm_match_test;
  import dcm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, got_dat;
  logic ack, bvalid;
  logic [2:0] match;
  logic [17:0] baddr;
  logic [15:0] bdata;
  int bad_count = 0, checks = 0, cyc_n = 0;
  // 250 MHz clock
  always #2 i_clk = ~i_clk;
  dcm_match uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_bus_valid(bvalid), .i_bus_addr(baddr), .i_bus_data(bdata),
    .o_match(match));
  dcm_cpu_model cpu (.i_clk(i_clk), .o_valid(bvalid), .o_addr(baddr), .o_data(bdata));
  task end_sim;
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // cut a hang short
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n > 3000) begin
      bad_count++;
      end_sim;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task chk_m(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t match %b want %b", $time, got, exp);
    end
  endtask : chk_m
  // classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h00_0000, d};
    do @(posedge i_clk); while (ack !== 1'b1);
    got_dat = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge i_clk);
  endtask : wb
  task rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(got_dat, {24'h00_0000, e});
  endtask : rd
  // bus cycle, then judge the match flags one cycle on
  task bus(input logic [17:0] a, input logic [15:0] d, input logic [2:0] e);
    cpu.cycle(a, d);
    @(posedge i_clk);
    chk_m(match, e);
  endtask : bus
  task t_reset;
    rd(8'hA8, 8'h00);
    rd(8'hAC, 8'h00);
    rd(8'hB4, 8'h00);
  endtask : t_reset
  task t_regs;
    wb(1'b1, 8'hC0, 8'h70);
    wb(1'b1, 8'hA4, 8'h01);
    wb(1'b1, 8'hA8, 8'h12);
    wb(1'b1, 8'hAC, 8'h34);
    wb(1'b1, 8'hB0, 8'hAB);
    wb(1'b1, 8'hB4, 8'hCD);
    wb(1'b1, 8'hB8, 8'hF0);
    rd(8'hA8, 8'h12);
    rd(8'hAC, 8'h34);
    rd(8'hB0, 8'hAB);
    rd(8'hB4, 8'hCD);
    rd(8'hB8, 8'hF0);
    rd(8'hA4, 8'h01);
    rd(8'hC0, 8'h70);
  endtask : t_regs
  task t_match;
    bus(18'h1_1234, 16'hA0CD, 3'b001);
    bus(18'h1_1234, 16'hAFCD, 3'b001);
    bus(18'h1_1234, 16'hB0CD, 3'b000);
    bus(18'h1_1234, 16'hA0CC, 3'b000);
    bus(18'h1_1235, 16'hA0CD, 3'b000);
    bus(18'h1_0234, 16'hA0CD, 3'b000);
    bus(18'h0_1234, 16'hA0CD, 3'b000);
  endtask : t_match
  task t_mask;
    wb(1'b1, 8'hB8, 8'hFF);
    bus(18'h1_1234, 16'hABCD, 3'b001);
    bus(18'h1_1234, 16'hAACD, 3'b000);
    wb(1'b1, 8'hB8, 8'h00);
    bus(18'h1_1234, 16'h00CD, 3'b001);
    wb(1'b1, 8'hB8, 8'hF0);
    rd(8'hB8, 8'hF0);
  endtask : t_mask
  task t_status;
    cpu.cycle(18'h1_1234, 16'hA0CD);
    rd(8'hC4, 8'h01);
  endtask : t_status
  task t_tag;
    wb(1'b1, 8'hC0, 8'h74);
    bus(18'h1_1234, 16'h0000, 3'b001);
  endtask : t_tag
  task t_view;
    wb(1'b1, 8'hC0, 8'h71);
    rd(8'hB0, 8'h00);
    wb(1'b1, 8'hB0, 8'h55);
    wb(1'b1, 8'hB4, 8'h11);
    rd(8'hB8, 8'h00);
    wb(1'b1, 8'hA4, 8'h02);
    wb(1'b1, 8'hA8, 8'h56);
    wb(1'b1, 8'hAC, 8'h78);
    bus(18'h2_5678, 16'h0000, 3'b010);
    wb(1'b1, 8'hC0, 8'h72);
    wb(1'b1, 8'hA4, 8'h02);
    wb(1'b1, 8'hA8, 8'h56);
    wb(1'b1, 8'hAC, 8'h78);
    rd(8'hAC, 8'h78);
    bus(18'h2_5678, 16'h0000, 3'b110);
    wb(1'b1, 8'hC0, 8'h73);
    rd(8'hA8, 8'h00);
    wb(1'b1, 8'hA8, 8'hEE);
    wb(1'b1, 8'hC0, 8'h70);
    rd(8'hB0, 8'hAB);
    rd(8'hB4, 8'hCD);
    rd(8'hA8, 8'h12);
    wb(1'b1, 8'hC0, 8'h71);
    rd(8'hA8, 8'h56);
  endtask : t_view
  task t_enable;
    wb(1'b1, 8'hC0, 8'h60);
    bus(18'h1_1234, 16'hA0CD, 3'b000);
    bus(18'h2_5678, 16'h0000, 3'b110);
  endtask : t_enable
  task t_arm;
    wb(1'b1, 8'hC0, 8'h78);
    wb(1'b1, 8'hA8, 8'hFF);
    wb(1'b1, 8'hB0, 8'h00);
    rd(8'hA8, 8'h12);
    rd(8'hB0, 8'hAB);
    wb(1'b1, 8'hC0, 8'h70);
    wb(1'b1, 8'hA8, 8'h9A);
    rd(8'hA8, 8'h9A);
  endtask : t_arm
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_reset;
    t_regs;
    t_match;
    t_mask;
    t_status;
    t_tag;
    t_view;
    t_enable;
    @(posedge i_clk);
    t_arm;
    end_sim;
  end
endmodule : dcm_match_test
